// [logic/dsa_accum_params.svh]
`ifndef DSA_ACCUM_PARAMS_SVH
`define DSA_ACCUM_PARAMS_SVH
// accumulator and data word widths
`define DSA_ACC_W 40
`define DSA_WORD_W 16
// adder saturation limits, 9.31 and 1.31
`define DSA_POS40 40'h7fffffffff
`define DSA_NEG40 40'h8000000000
`define DSA_POS32 40'h007fffffff
`define DSA_NEG32 40'h0080000000
// data write saturation limits, 1.15
`define DSA_POS16 16'h7fff
`define DSA_NEG16 16'h8000
// round half point of the low word
`define DSA_HALF 16'h8000
// pointer step after an indirect write-back
`define DSA_WB_STEP 16'h0002
// largest shift magnitude
`define DSA_MAX_SHIFT 5'h10
// reset values
`define DSA_ACC_RST 40'h0000000000
`define DSA_PTR_RST 16'h0000
`endif

// [logic/dsa_pkg.sv]
`default_nettype none
package dsa_pkg;
  // operation presented to the adder in a cycle
  typedef enum logic [3:0] {
    DSA_OP_NOP    = 4'h0,
    DSA_OP_MAC    = 4'h1,
    DSA_OP_MSC    = 4'h2,
    DSA_OP_MPY    = 4'h3,
    DSA_OP_MPYN   = 4'h4,
    DSA_OP_ED     = 4'h5,
    DSA_OP_SQUARED_DIFFERENCE_ACC_OP   = 4'h6,
    DSA_OP_CLR    = 4'h7,
    DSA_OP_MOVSAC = 4'h8,
    DSA_OP_LOAD   = 4'h9
  } dsa_op_e;
  // barrel shifter operand source
  typedef enum logic [1:0] {
    DSA_SRC_ACC_A = 2'h0,
    DSA_SRC_ACC_B = 2'h1,
    DSA_SRC_XBUS  = 2'h2
  } dsa_src_e;
  // write-back addressing
  typedef enum logic {
    DSA_WB_DIRECT   = 1'b0,
    DSA_WB_INDIRECT = 1'b1
  } dsa_wb_e;
endpackage : dsa_pkg
`default_nettype wire

// [logic/dsa_accum.sv]
// Implementation choices: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "dsa_accum_params.svh"
module dsa_accum #(
  parameter int ACC_W  = `DSA_ACC_W,
  parameter int WORD_W = `DSA_WORD_W
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // adder operation
  input  wire dsa_pkg::dsa_op_e     op_kind,
  input  wire logic                 op_target_b,
  input  wire logic [ACC_W-1:0]     op_operand,
  // core configuration
  input  wire logic                 acc_a_sat_enable,
  input  wire logic                 acc_b_sat_enable,
  input  wire logic                 sat_width_select,
  input  wire logic                 data_write_sat_enable,
  input  wire logic                 rounding_mode_select,
  // trap control
  input  wire logic                 acc_a_overflow_trap_en,
  input  wire logic                 acc_b_overflow_trap_en,
  input  wire logic                 catastrophic_trap_en,
  // software clears of sticky flags
  input  wire logic                 clear_acc_a_saturated,
  input  wire logic                 clear_acc_b_saturated,
  // accumulator store and write-back
  input  wire logic                 store_req,
  input  wire logic                 store_src_b,
  input  wire logic                 store_round,
  input  wire logic [WORD_W-1:0]    store_addr,
  input  wire logic                 wb_req,
  input  wire dsa_pkg::dsa_wb_e     wb_mode,
  // barrel shifter
  input  wire logic                 shift_req,
  input  wire dsa_pkg::dsa_src_e    shift_src,
  input  wire logic signed [5:0]    shift_amt,
  input  wire logic                 shift_arith,
  input  wire logic [WORD_W-1:0]    xbus_rd_data,
  // accumulators and status
  output logic [ACC_W-1:0]          acc_a,
  output logic [ACC_W-1:0]          acc_b,
  output logic                      acc_a_guard_overflow,
  output logic                      acc_b_guard_overflow,
  output logic                      acc_a_saturated,
  output logic                      acc_b_saturated,
  output logic                      any_guard_overflow,
  output logic                      any_saturated,
  output logic                      arith_trap_req,
  // x bus write
  output logic                      xbus_wr_valid,
  output logic [WORD_W-1:0]         xbus_wr_addr,
  output logic [WORD_W-1:0]         xbus_wr_data,
  output logic [WORD_W-1:0]         writeback_pointer_reg,
  // shifter results
  output logic                      shift_valid,
  output logic [ACC_W-1:0]          shift_result,
  output logic [WORD_W-1:0]         shift_result_core
);
  import dsa_pkg::*;

  logic [ACC_W-1:0] src_acc;
  logic [ACC_W-1:0] add_in;
  logic [ACC_W-1:0] add_op;
  logic             add_sub;
  logic             add_pass;
  logic [ACC_W:0]   sum;
  logic             ovf39;
  logic             ovf31;
  logic             guard;
  logic             sat_en;
  logic             mode32;
  logic [ACC_W-1:0] next_acc;
  logic             sat_evt;
  logic             next_guard;
  logic             wb_ok;

  // operand selection; load-type ops feed zero on the accumulator side
  always_comb begin
    src_acc  = op_target_b ? acc_b : acc_a;
    add_in   = src_acc;
    add_op   = op_operand;
    add_sub  = 1'b0;
    add_pass = 1'b1;
    unique case (op_kind)
      DSA_OP_MAC, DSA_OP_SQUARED_DIFFERENCE_ACC_OP: add_sub = 1'b0;
      DSA_OP_MSC: add_sub = 1'b1;
      DSA_OP_MPY, DSA_OP_ED, DSA_OP_LOAD: add_in = '0;
      DSA_OP_MPYN: begin
        add_in  = '0;
        add_sub = 1'b1;
      end
      DSA_OP_CLR: begin
        add_in = '0;
        add_op = '0;
      end
      DSA_OP_NOP, DSA_OP_MOVSAC: add_pass = 1'b0;
      default: add_pass = 1'b0;
    endcase
  end

  // one extra bit keeps the true sign past a bit 39 overflow
  always_comb begin
    if (add_sub) begin
      sum = {add_in[ACC_W-1], add_in} - {add_op[ACC_W-1], add_op};
    end else begin
      sum = {add_in[ACC_W-1], add_in} + {add_op[ACC_W-1], add_op};
    end
  end

  assign ovf39  = sum[ACC_W] ^ sum[ACC_W-1];
  assign ovf31  = ~((&sum[ACC_W:31]) | ~(|sum[ACC_W:31]));
  assign guard  = ~((&sum[ACC_W-1:32]) | ~(|sum[ACC_W-1:32]));
  assign sat_en = op_target_b ? acc_b_sat_enable : acc_a_sat_enable;
  assign mode32 = sat_en & ~sat_width_select;

  // saturation decision and value
  always_comb begin
    next_acc   = sum[ACC_W-1:0];
    sat_evt    = ovf39;
    next_guard = mode32 ? 1'b0 : guard;
    if (sat_en && sat_width_select) begin
      sat_evt = ovf39;
      if (ovf39) begin
        next_acc = sum[ACC_W] ? `DSA_NEG40 : `DSA_POS40;
      end
    end else if (sat_en) begin
      sat_evt = ovf31;
      if (ovf31) begin
        next_acc = sum[ACC_W] ? `DSA_NEG32 : `DSA_POS32;
      end
    end
  end

  // target accumulator update
  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc_a <= `DSA_ACC_RST;
      acc_b <= `DSA_ACC_RST;
    end else if (add_pass) begin
      if (op_target_b) begin
        acc_b <= next_acc;
      end else begin
        acc_a <= next_acc;
      end
    end
  end

  // guard flags follow every pass through the adder
  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc_a_guard_overflow <= 1'b0;
      acc_b_guard_overflow <= 1'b0;
    end else if (add_pass) begin
      if (op_target_b) begin
        acc_b_guard_overflow <= next_guard;
      end else begin
        acc_a_guard_overflow <= next_guard;
      end
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc_a_saturated <= 1'b0;
      acc_b_saturated <= 1'b0;
    end else begin
      if (add_pass && !op_target_b && sat_evt) begin
        acc_a_saturated <= 1'b1;
      end else if (clear_acc_a_saturated) begin
        acc_a_saturated <= 1'b0;
      end
      if (add_pass && op_target_b && sat_evt) begin
        acc_b_saturated <= 1'b1;
      end else if (clear_acc_b_saturated) begin
        acc_b_saturated <= 1'b0;
      end
    end
  end

  // combined flags and trap level, one cycle behind the flags
  always_ff @(posedge clk) begin
    if (!rstn) begin
      any_guard_overflow <= 1'b0;
      any_saturated      <= 1'b0;
      arith_trap_req     <= 1'b0;
    end else begin
      any_guard_overflow <= acc_a_guard_overflow | acc_b_guard_overflow;
      any_saturated      <= acc_a_saturated | acc_b_saturated;
      arith_trap_req     <= (acc_a_guard_overflow & acc_a_overflow_trap_en)
                          | (acc_b_guard_overflow & acc_b_overflow_trap_en)
                          | (catastrophic_trap_en &
                             ((acc_a_saturated & ~acc_a_sat_enable) |
                              (acc_b_saturated & ~acc_b_sat_enable)));
    end
  end

  // round and data-write saturation
  logic [ACC_W-1:0] st_acc;
  logic             st_rnd;
  logic             rnd_inc;
  logic [24:0]      rnd_full;
  logic             dw_pos;
  logic             dw_neg;
  logic [15:0]      st_word;

  assign wb_ok = wb_req & (op_kind == DSA_OP_MAC || op_kind == DSA_OP_MSC ||
                 op_kind == DSA_OP_CLR || op_kind == DSA_OP_MOVSAC);
  // write-back reads the accumulator the op does not target
  assign st_acc = wb_ok ? (op_target_b ? acc_a : acc_b) : (store_src_b ? acc_b : acc_a);
  assign st_rnd = wb_ok | store_round;

  // convergent rounding only differs at an exact half
  assign rnd_inc = st_rnd & st_acc[15] &
                   (~rounding_mode_select | (st_acc[15:0] != `DSA_HALF) | st_acc[16]);
  assign rnd_full = {st_acc[ACC_W-1], st_acc[ACC_W-1:16]} + {24'h000000, rnd_inc};
  // the sign comes from bit 39 so a rounding carry cannot flip it
  assign dw_pos = ~st_acc[ACC_W-1] & (|rnd_full[24:15]);
  assign dw_neg = st_acc[ACC_W-1] & ~(&rnd_full[24:15]);

  always_comb begin
    st_word = rnd_full[15:0];
    if (data_write_sat_enable && dw_pos) begin
      st_word = `DSA_POS16;
    end else if (data_write_sat_enable && dw_neg) begin
      st_word = `DSA_NEG16;
    end
  end

  // x bus write and write-back pointer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      xbus_wr_valid         <= 1'b0;
      xbus_wr_addr          <= '0;
      xbus_wr_data          <= '0;
      writeback_pointer_reg <= `DSA_PTR_RST;
    end else begin
      xbus_wr_valid <= 1'b0;
      if (wb_ok && wb_mode == DSA_WB_DIRECT) begin
        writeback_pointer_reg <= st_word;
      end else if (wb_ok) begin
        xbus_wr_valid         <= 1'b1;
        xbus_wr_addr          <= writeback_pointer_reg;
        xbus_wr_data          <= st_word;
        writeback_pointer_reg <= writeback_pointer_reg + `DSA_WB_STEP;
      end else if (store_req) begin
        xbus_wr_valid <= 1'b1;
        xbus_wr_addr  <= store_addr;
        xbus_wr_data  <= st_word;
      end
    end
  end

  // barrel shifter operand placement
  logic [ACC_W-1:0] sh_in;
  logic [4:0]       sh_mag;
  logic             sh_right;
  logic [ACC_W-1:0] sh_out;

  assign sh_right = ~shift_amt[5];
  // amounts beyond sixteen clamp to sixteen
  always_comb begin
    sh_mag = shift_amt[5] ? 5'(-shift_amt) : shift_amt[4:0];
    // minus thirty-two has no five-bit magnitude and would wrap to zero
    if (sh_mag > `DSA_MAX_SHIFT || (shift_amt[5] && shift_amt[4:0] == 5'h00)) begin
      sh_mag = `DSA_MAX_SHIFT;
    end
  end

  always_comb begin
    unique case (shift_src)
      DSA_SRC_ACC_A: sh_in = acc_a;
      DSA_SRC_ACC_B: sh_in = acc_b;
      DSA_SRC_XBUS: begin
        if (sh_right) begin
          sh_in = {{8{shift_arith & xbus_rd_data[15]}}, xbus_rd_data, 16'h0000};
        end else begin
          sh_in = {24'h000000, xbus_rd_data};
        end
      end
      default: sh_in = '0;
    endcase
  end

  always_comb begin
    if (!sh_right) begin
      sh_out = sh_in << sh_mag;
    end else if (shift_arith) begin
      sh_out = ACC_W'($signed(sh_in) >>> sh_mag);
    end else begin
      sh_out = sh_in >> sh_mag;
    end
  end

  // shifter results are registered in the request cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shift_valid       <= 1'b0;
      shift_result      <= '0;
      shift_result_core <= '0;
    end else begin
      shift_valid <= shift_req;
      if (shift_req) begin
        shift_result      <= sh_out;
        shift_result_core <= sh_right ? sh_out[31:16] : sh_out[15:0];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_limit_40: assert property (add_pass && sat_en && sat_width_select && ovf39 && !sum[ACC_W] && !op_target_b
    |=> acc_a == `DSA_POS40 && acc_a_saturated) else $error("40-bit limit not loaded");
  a_limit_32: assert property (add_pass && mode32 && ovf31 && sum[ACC_W] && op_target_b
    |=> acc_b == `DSA_NEG32 && acc_b_saturated) else $error("32-bit limit not loaded");
  a_no_guard_32: assert property (add_pass && mode32 && !op_target_b
    |=> !acc_a_guard_overflow) else $error("guard set in 32-bit mode");
  a_guard_track: assert property (add_pass && !mode32 && op_target_b
    |=> acc_b_guard_overflow == $past(guard)) else $error("guard flag wrong");
  a_sat_sticky: assert property (acc_a_saturated && !clear_acc_a_saturated
    |=> acc_a_saturated) else $error("saturated flag dropped");
  a_wrap_cat: assert property (add_pass && !sat_en && ovf39 && !op_target_b
    |=> acc_a == $past(sum[ACC_W-1:0]) && acc_a_saturated) else $error("no wrap");
  a_combined: assert property (##1 any_saturated == ($past(acc_a_saturated) | $past(acc_b_saturated)))
    else $error("combined flag wrong");
  a_trap_guard: assert property (acc_a_guard_overflow && acc_a_overflow_trap_en
    |=> arith_trap_req) else $error("guard trap missing");
  a_trap_cat: assert property (acc_b_saturated && !acc_b_sat_enable && catastrophic_trap_en
    |=> arith_trap_req) else $error("catastrophic trap missing");
  a_wb_step: assert property (wb_ok && wb_mode == DSA_WB_INDIRECT
    |=> xbus_wr_valid && writeback_pointer_reg == $past(writeback_pointer_reg) + `DSA_WB_STEP)
    else $error("pointer not stepped");
  a_trunc_store: assert property (store_req && !wb_ok && !store_round && !data_write_sat_enable
    |=> xbus_wr_data == $past(st_acc[31:16])) else $error("truncation wrong");
  a_dw_clamp: assert property (data_write_sat_enable && dw_pos && (store_req || wb_ok)
    && !(wb_ok && wb_mode == DSA_WB_DIRECT) |=> xbus_wr_data == `DSA_POS16)
    else $error("write not clamped");
  a_shift_zero: assert property (shift_req && shift_amt == 6'sd0 && shift_src == DSA_SRC_ACC_A
    |=> shift_result == $past(acc_a)) else $error("zero shift changed data");

  c_sat40: cover property (add_pass && sat_en && sat_width_select && ovf39);
  c_sat32: cover property (add_pass && mode32 && ovf31);
  c_wb_ind: cover property (wb_ok && wb_mode == DSA_WB_INDIRECT);
  c_conv_half: cover property (store_req && rounding_mode_select && st_acc[15:0] == `DSA_HALF);
endmodule : dsa_accum
`default_nettype wire

// [verif/dsa_xbus_model.sv]
`timescale 1ns/1ns
`default_nettype none
module dsa_xbus_model (
  // clock
  input  wire logic        clk,
  // x bus write from the datapath
  input  wire logic        wr_valid,
  input  wire logic [15:0] wr_addr,
  input  wire logic [15:0] wr_data,
  // x bus read for the shifter
  input  wire logic [15:0] rd_addr,
  output logic      [15:0] rd_data
);
  logic [15:0] mem [16];
  // unwritten words hold a busy pattern so stale zeros never pass a check
  initial for (int i = 0; i < 16; i++) mem[i] = 16'ha5c3 ^ 16'(i);
  // a word lands on the edge that closes the strobe cycle
  always @(posedge clk) begin
    if (wr_valid) begin
      mem[wr_addr[4:1]] <= wr_data;
    end
  end
  assign rd_data = mem[rd_addr[4:1]];
endmodule : dsa_xbus_model
`default_nettype wire

// [verif/dsp_accumulator_round_saturate_shift_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module dsp_accumulator_round_saturate_shift_bench;
  import dsa_pkg::*;
  logic clk = 1'b0, rstn = 1'b0;
  dsa_op_e op_kind = DSA_OP_NOP;
  logic op_target_b = 1'b0;
  logic [39:0] op_operand = '0;
  logic acc_a_sat_enable = 1'b0, acc_b_sat_enable = 1'b0, sat_width_select = 1'b0;
  logic data_write_sat_enable = 1'b0, rounding_mode_select = 1'b0;
  logic acc_a_overflow_trap_en = 1'b0, acc_b_overflow_trap_en = 1'b0, catastrophic_trap_en = 1'b0;
  logic clear_acc_a_saturated = 1'b0, clear_acc_b_saturated = 1'b0;
  logic store_req = 1'b0, store_src_b = 1'b0, store_round = 1'b0, wb_req = 1'b0;
  logic [15:0] store_addr = 16'h0010, rd_addr = 16'h0010;
  dsa_wb_e wb_mode = DSA_WB_DIRECT;
  dsa_src_e shift_src = DSA_SRC_ACC_A;
  logic shift_req = 1'b0, shift_arith = 1'b0;
  logic signed [5:0] shift_amt = '0;
  wire logic [15:0] xbus_rd_data;
  logic [39:0] acc_a, acc_b, shift_result;
  logic acc_a_guard_overflow, acc_b_guard_overflow, acc_a_saturated, acc_b_saturated;
  logic any_guard_overflow, any_saturated, arith_trap_req, xbus_wr_valid, shift_valid;
  logic [15:0] xbus_wr_addr, xbus_wr_data, writeback_pointer_reg, shift_result_core;
  int n_errors = 0, n_tests = 0;
  // store table: accumulator, {src_b, data sat, convergent, round}, word
  logic [39:0] t_acc [8] = '{40'h0012348000, 40'h0012348000, 40'h0012348000, 40'h0012358000,
                             40'h0012347fff, 40'h0123450000, 40'h0123450000, 40'hfe00000000};
  logic [3:0]  t_ctl [8] = '{4'h0, 4'h1, 4'h3, 4'hb, 4'h1, 4'h4, 4'h0, 4'hc};
  logic [15:0] t_exp [8] = '{16'h1234, 16'h1235, 16'h1234, 16'h1236, 16'h1234, 16'h7fff, 16'h2345, 16'h8000};

  dsa_accum dut_u (
    .clk, .rstn, .op_kind, .op_target_b, .op_operand, .acc_a_sat_enable, .acc_b_sat_enable,
    .sat_width_select, .data_write_sat_enable, .rounding_mode_select, .acc_a_overflow_trap_en,
    .acc_b_overflow_trap_en, .catastrophic_trap_en, .clear_acc_a_saturated, .clear_acc_b_saturated,
    .store_req, .store_src_b, .store_round, .store_addr, .wb_req, .wb_mode, .shift_req, .shift_src,
    .shift_amt, .shift_arith, .xbus_rd_data, .acc_a, .acc_b, .acc_a_guard_overflow,
    .acc_b_guard_overflow, .acc_a_saturated, .acc_b_saturated, .any_guard_overflow, .any_saturated,
    .arith_trap_req, .xbus_wr_valid, .xbus_wr_addr, .xbus_wr_data, .writeback_pointer_reg,
    .shift_valid, .shift_result, .shift_result_core
  );
  dsa_xbus_model xbus_u (.clk, .wr_valid(xbus_wr_valid), .wr_addr(xbus_wr_addr),
    .wr_data(xbus_wr_data), .rd_addr(rd_addr), .rd_data(xbus_rd_data));

  always #5 clk = ~clk;

  // verdict and end of run, also reached from an expired wait
  task test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task chk40(input string nm, input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk40

  task chk16(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk16

  task chk1(input string nm, input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %b got %b", nm, exp, got);
    end
  endtask : chk1

  // one adder pass; results are settled 1 ns after the taking edge
  task op(input dsa_op_e k, input logic tb, input logic [39:0] v, input logic wb = 1'b0,
          input dsa_wb_e m = DSA_WB_INDIRECT);
    @(posedge clk);
    op_kind <= k;
    op_target_b <= tb;
    op_operand <= v;
    wb_req <= wb;
    wb_mode <= m;
    @(posedge clk);
    op_kind <= DSA_OP_NOP;
    wb_req <= 1'b0;
    #1;
  endtask : op

  // combined flags and trap trail the flags by one cycle
  task lag();
    @(posedge clk);
    #1;
  endtask : lag

  task clr(input logic b);
    @(posedge clk);
    clear_acc_a_saturated <= !b;
    clear_acc_b_saturated <= b;
    @(posedge clk);
    clear_acc_a_saturated <= 1'b0;
    clear_acc_b_saturated <= 1'b0;
    #1;
  endtask : clr

  task st(input logic [3:0] c, input logic [15:0] exp);
    int n;
    @(posedge clk);
    store_req <= 1'b1;
    {store_src_b, data_write_sat_enable, rounding_mode_select, store_round} <= c;
    @(posedge clk);
    store_req <= 1'b0;
    #1;
    n = 0;
    while (xbus_wr_valid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 4) begin
      n_errors++;
      $display("BAD xbus_wr_valid exp 1 got 0");
      test_done();
    end
    chk16("wr_data", xbus_wr_data, exp);
  endtask : st

  task sh(input dsa_src_e s, input logic signed [5:0] a, input logic ar, input logic [39:0] e40,
          input logic [15:0] e16);
    @(posedge clk);
    shift_req <= 1'b1;
    shift_src <= s;
    shift_amt <= a;
    shift_arith <= ar;
    @(posedge clk);
    shift_req <= 1'b0;
    #1;
    chk1("shift_valid", shift_valid, 1'b1);
    chk40("shift_result", shift_result, e40);
    chk16("shift_core", shift_result_core, e16);
  endtask : sh

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    // guard overflow with its trap, saturation off
    @(posedge clk);
    acc_a_overflow_trap_en <= 1'b1;
    op(DSA_OP_LOAD, 1'b0, 40'h0100000000);
    chk40("acc_a", acc_a, 40'h0100000000);
    chk1("guard_a", acc_a_guard_overflow, 1'b1);
    chk1("guard_b", acc_b_guard_overflow, 1'b0);
    lag();
    chk1("any_guard", any_guard_overflow, 1'b1);
    chk1("trap", arith_trap_req, 1'b1);
    op(DSA_OP_LOAD, 1'b0, 40'h0);
    chk1("guard_a", acc_a_guard_overflow, 1'b0);
    lag();
    chk1("trap", arith_trap_req, 1'b0);
    // catastrophic overflow wraps and stays flagged until cleared
    @(posedge clk);
    acc_a_overflow_trap_en <= 1'b0;
    catastrophic_trap_en <= 1'b1;
    op(DSA_OP_LOAD, 1'b0, 40'h7fffffffff);
    op(DSA_OP_MAC, 1'b0, 40'h1);
    chk40("acc_a", acc_a, 40'h8000000000);
    chk1("sat_a", acc_a_saturated, 1'b1);
    lag();
    chk1("any_sat", any_saturated, 1'b1);
    chk1("trap", arith_trap_req, 1'b1);
    op(DSA_OP_LOAD, 1'b0, 40'h0);
    chk1("sat_a", acc_a_saturated, 1'b1);
    clr(1'b0);
    chk1("sat_a", acc_a_saturated, 1'b0);
    op(DSA_OP_LOAD, 1'b1, 40'h8000000000);
    op(DSA_OP_MSC, 1'b1, 40'h1);
    chk40("acc_b", acc_b, 40'h7fffffffff);
    chk1("sat_b", acc_b_saturated, 1'b1);
    lag();
    chk1("trap", arith_trap_req, 1'b1);
    clr(1'b1);
    // 40-bit saturation on both accumulators
    @(posedge clk);
    catastrophic_trap_en <= 1'b0;
    acc_a_sat_enable <= 1'b1;
    acc_b_sat_enable <= 1'b1;
    sat_width_select <= 1'b1;
    op(DSA_OP_LOAD, 1'b0, 40'h7fffffffff);
    op(DSA_OP_MAC, 1'b0, 40'h1);
    chk40("acc_a", acc_a, 40'h7fffffffff);
    chk1("sat_a", acc_a_saturated, 1'b1);
    op(DSA_OP_LOAD, 1'b1, 40'h8000000000);
    op(DSA_OP_MSC, 1'b1, 40'h1);
    chk40("acc_b", acc_b, 40'h8000000000);
    chk1("sat_b", acc_b_saturated, 1'b1);
    clr(1'b0);
    clr(1'b1);
    // 32-bit saturation ignores the guard bits
    @(posedge clk);
    sat_width_select <= 1'b0;
    // a 32-bit pass on acc_b also drops its stale guard flag
    op(DSA_OP_LOAD, 1'b1, 40'hff00000000);
    chk40("acc_b", acc_b, 40'h0080000000);
    chk1("guard_b", acc_b_guard_overflow, 1'b0);
    op(DSA_OP_LOAD, 1'b0, 40'h0100000000);
    chk40("acc_a", acc_a, 40'h007fffffff);
    chk1("guard_a", acc_a_guard_overflow, 1'b0);
    chk1("sat_a", acc_a_saturated, 1'b1);
    lag();
    chk1("any_guard", any_guard_overflow, 1'b0);
    op(DSA_OP_LOAD, 1'b0, 40'hff00000000);
    chk40("acc_a", acc_a, 40'h0080000000);
    clr(1'b0);
    clr(1'b1);
    @(posedge clk);
    acc_a_sat_enable <= 1'b0;
    acc_b_sat_enable <= 1'b0;
    // stores: truncate, both rounding modes, data write saturation
    for (int i = 0; i < 8; i++) begin
      op(DSA_OP_LOAD, t_ctl[i][3], t_acc[i]);
      st(t_ctl[i], t_exp[i]);
    end
    chk16("wr_addr", xbus_wr_addr, 16'h0010);
    // write-back of the other accumulator, indirect then direct, then refused
    op(DSA_OP_LOAD, 1'b1, 40'h0000018000);
    op(DSA_OP_MAC, 1'b0, 40'h0, 1'b1, DSA_WB_INDIRECT);
    chk1("wr_valid", xbus_wr_valid, 1'b1);
    chk16("wr_addr", xbus_wr_addr, 16'h0000);
    chk16("wr_data", xbus_wr_data, 16'h0002);
    chk16("wb_ptr", writeback_pointer_reg, 16'h0002);
    op(DSA_OP_LOAD, 1'b1, 40'h0000340000);
    op(DSA_OP_MSC, 1'b0, 40'h0, 1'b1, DSA_WB_DIRECT);
    chk16("wb_ptr", writeback_pointer_reg, 16'h0034);
    chk1("wr_valid", xbus_wr_valid, 1'b0);
    op(DSA_OP_MPY, 1'b0, 40'h0, 1'b1, DSA_WB_INDIRECT);
    chk1("wr_valid", xbus_wr_valid, 1'b0);
    chk16("wb_ptr", writeback_pointer_reg, 16'h0034);
    // further adder operations: negate, accumulate, clear
    op(DSA_OP_MPYN, 1'b0, 40'h3);
    chk40("acc_a", acc_a, 40'hfffffffffd);
    op(DSA_OP_SQUARED_DIFFERENCE_ACC_OP, 1'b0, 40'h5);
    chk40("acc_a", acc_a, 40'h0000000002);
    op(DSA_OP_CLR, 1'b0, 40'h5);
    chk40("acc_a", acc_a, 40'h0000000000);
    // shifter on accumulators and on the word read back over the bus
    op(DSA_OP_LOAD, 1'b0, 40'h8012345678);
    sh(DSA_SRC_ACC_A, 6'sd4, 1'b1, 40'hf801234567, 16'h0123);
    sh(DSA_SRC_ACC_A, 6'sd4, 1'b0, 40'h0801234567, 16'h0123);
    sh(DSA_SRC_ACC_A, -6'sd4, 1'b0, 40'h0123456780, 16'h6780);
    sh(DSA_SRC_ACC_A, 6'sd0, 1'b0, 40'h8012345678, 16'h1234);
    sh(DSA_SRC_ACC_B, -6'sd16, 1'b0, 40'h3400000000, 16'h0000);
    sh(DSA_SRC_ACC_B, 6'sh20, 1'b0, 40'h3400000000, 16'h0000);
    sh(DSA_SRC_XBUS, 6'sd4, 1'b1, 40'hfff8000000, 16'hf800);
    sh(DSA_SRC_XBUS, -6'sd4, 1'b0, 40'h0000080000, 16'h0000);
    test_done();
  end
endmodule : dsp_accumulator_round_saturate_shift_bench
`default_nettype wire
